// file: bus_own_pkg.sv
// Package: constants, states and carrier structs for the bus ownership block
package bus_own_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WARM_RESET_CLOCKS = 15;
  localparam int unsigned NMI_LOW_CLOCKS = 4;
  localparam logic [3:0] NMI_LOW_CNT_W1 = 4'h4;
  localparam logic [7:0] NMI_VECTOR = 8'h02;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SNOOP_LSB = 4;
  localparam logic [1:0] INTA_COUNT = 2'h2;
  localparam logic [3:0] RESET_CNT_INIT = 4'h0;
  localparam logic [3:0] RESET_CNT_MAX = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b011,
    ST_YIELD = 3'b100
  } bus_state_t;

  // Bus cycle request from the core
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic locked;
    logic more;
    logic code_nc_prefetch;
  } cycle_req_t;

  // Ready / termination inputs, synchronous to clk
  typedef struct packed {
    logic ready_n;
    logic burst_ready_n;
    logic last_n;
  } cycle_term_t;

  // Interrupt dispatch to the core
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [7:0] vector;
  } irq_dispatch_t;

  // Snoop invalidate to the cache
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:SNOOP_LSB] line;
  } snoop_t;
endpackage

// file: sync2.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: irq_front.sv
// Interrupt front end: synchronised maskable level and non-maskable edge
`timescale 1ns/1ps
module irq_front
  import bus_own_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Raw pins
  input wire logic maskable_irq_in,
  input wire logic nmi_in,
  // Core side
  input wire logic nmi_taken,
  input wire logic interrupt_return_instr,
  output logic maskable_irq_in_level,
  output logic nmi_pending
);
  logic [1:0] sync_q;
  logic nmi_prev_reg;
  logic [3:0] low_cnt_reg;
  logic nmi_masked_reg;

  // Both pins synchronised before any detection
  sync2 #(.WIDTH(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d({nmi_in, maskable_irq_in}),
    .q(sync_q)
  );

  assign maskable_irq_in_level = sync_q[0];

  // Count low time ahead of the edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nmi_prev_reg <= 1'b0;
      low_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      nmi_prev_reg <= sync_q[1];
      if (sync_q[1])
        low_cnt_reg <= 4'h0;
      else if (low_cnt_reg != NMI_LOW_CNT_W1)
        low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  // Masked from acceptance until return instruction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nmi_pending <= 1'b0;
      nmi_masked_reg <= 1'b0;
    end else if (clk_en) begin
      if (sync_q[1] && !nmi_prev_reg && low_cnt_reg == NMI_LOW_CNT_W1 && !nmi_masked_reg) begin
        nmi_pending <= 1'b1;
      end else if (nmi_taken) begin
        nmi_pending <= 1'b0;
      end
      if (nmi_taken)
        nmi_masked_reg <= 1'b1;
      else if (interrupt_return_instr)
        nmi_masked_reg <= 1'b0;
    end
  end
endmodule

// file: cpu_bus_ownership_irq_snoop.sv
// Bus ownership, interrupt acceptance and snoop invalidation for the processor bus
`timescale 1ns/1ps
module cpu_bus_ownership_irq_snoop
  import bus_own_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Core cycle requests
  input wire cycle_req_t core_req,
  output logic core_req_ready,
  output logic [31:0] core_rdata,
  output logic core_rdata_valid,
  // Processor flags
  input wire logic [31:0] processor_flags_register,
  input wire logic interrupt_return_instr,
  output irq_dispatch_t irq_dispatch,
  // Interrupt pins
  input wire logic maskable_irq_in,
  input wire logic nmi_in,
  // Arbitration pins
  input wire logic hold_request,
  input wire logic bus_yield_now_n,
  input wire logic address_float_request,
  output logic bus_request_out,
  output logic bus_grant_ack,
  // Cycle pins
  output logic cycle_start_strobe_n,
  output logic cycle_inta,
  output logic cycle_lock_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe_n,
  output logic bus_oe_n,
  input wire cycle_term_t term,
  input wire logic [31:0] data_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic snoop_address_strobe_n,
  // Error outputs kept driven
  input wire logic parity_error,
  input wire logic fp_error,
  output logic parity_error_out_n,
  output logic fp_error_out_n,
  // Cache snoop and test modes
  output snoop_t snoop_inval,
  output logic self_test_req
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int IF_BIT = 9;
  logic [2:0] arb_q;
  logic hold_s, yield_s, afloat_s;
  logic maskable_irq_in_level, nmi_pending, nmi_taken;

  sync2 #(.WIDTH(3)) u_arb_sync (
    .clk(clk),
    .reset_n(1'b1),
    .clk_en(clk_en),
    .d({hold_request, ~bus_yield_now_n, address_float_request}),
    .q(arb_q)
  );
  assign hold_s = arb_q[2];
  assign yield_s = arb_q[1];
  assign afloat_s = arb_q[0];

  irq_front u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .maskable_irq_in(maskable_irq_in),
    .nmi_in(nmi_in),
    .nmi_taken(nmi_taken),
    .interrupt_return_instr(interrupt_return_instr),
    .maskable_irq_in_level(maskable_irq_in_level),
    .nmi_pending(nmi_pending)
  );

  // ==========================================================
  // Test mode latch at reset release
  // ==========================================================
  logic reset_d_reg;
  logic [3:0] reset_cnt_reg;

  always_ff @(posedge clk) begin
    if (clk_en) begin
      reset_d_reg <= reset_n;
      if (!reset_n && reset_cnt_reg != RESET_CNT_MAX)
        reset_cnt_reg <= reset_cnt_reg + 4'h1;
      else if (reset_n)
        reset_cnt_reg <= RESET_CNT_INIT;
    end
  end

  // Caught on the first edge after release, not by the reset itself
  always_ff @(posedge clk) begin
    if (!reset_n)
      self_test_req <= 1'b0;
    else if (clk_en && !reset_d_reg)
      self_test_req <= afloat_s;
  end

  // ==========================================================
  // Interrupt acceptance
  // ==========================================================
  logic maskable_irq_in_busy_reg;
  logic [1:0] inta_done_reg;
  logic inta_want;

  assign nmi_taken = nmi_pending && !maskable_irq_in_busy_reg;
  assign inta_want = maskable_irq_in_busy_reg && inta_done_reg != INTA_COUNT;

  // ==========================================================
  // Bus cycle sequencer
  // ==========================================================
  bus_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic locked_reg, more_reg, prefetch_reg, is_inta_reg;
  logic ready_hit, pending, cycle_end, lock_seq;
  logic [ADDR_W-1:0] addr_load;

  // New address must be on the pins in the strobe clock itself
  assign addr_load = inta_want ? '0 : core_req.addr;

  // Backoff suppresses any ready in the same clock
  assign ready_hit = (!term.ready_n || !term.burst_ready_n) && !yield_s;
  assign pending = core_req.valid || inta_want;
  assign cycle_end = state_reg == ST_WAIT && ready_hit && (!term.ready_n || !term.last_n);
  assign lock_seq = locked_reg || is_inta_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (yield_s)
          state_next = ST_YIELD;
        else if (hold_s)
          state_next = ST_HOLD;
        else if (pending && !afloat_s)
          state_next = ST_START;
      end
      ST_START: begin
        state_next = yield_s ? ST_YIELD : ST_WAIT;
      end
      ST_WAIT: begin
        if (yield_s)
          state_next = ST_YIELD;
        else if (cycle_end && hold_s && !(lock_seq && more_reg))
          state_next = ST_HOLD;
        else if (cycle_end)
          state_next = ST_IDLE;
      end
      ST_HOLD: begin
        if (yield_s)
          state_next = ST_YIELD;
        else if (!hold_s)
          state_next = ST_IDLE;
      end
      ST_YIELD: begin
        if (!yield_s && hold_s && prefetch_reg)
          state_next = ST_HOLD;
        else if (!yield_s && prefetch_reg == 1'b0 && more_reg)
          state_next = ST_START;
        else if (!yield_s)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer runs during reset too so takeover is honoured
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (!reset_n && !hold_s && !yield_s)
        state_reg <= ST_IDLE;
      else if (!reset_n)
        state_reg <= yield_s ? ST_YIELD : ST_HOLD;
      else
        state_reg <= state_next;
    end
  end

  // Latch cycle attributes at cycle start; kept for restart
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg <= '0;
      locked_reg <= 1'b0;
      more_reg <= 1'b0;
      prefetch_reg <= 1'b0;
      is_inta_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ST_IDLE && state_next == ST_START) begin
        addr_reg <= addr_load;
        locked_reg <= inta_want ? 1'b1 : core_req.locked;
        more_reg <= inta_want ? (inta_done_reg == 2'h0) : core_req.more;
        prefetch_reg <= inta_want ? 1'b0 : core_req.code_nc_prefetch;
        is_inta_reg <= inta_want;
      end else if (state_reg == ST_YIELD && state_next != ST_YIELD) begin
        more_reg <= 1'b1;
      end else if (cycle_end) begin
        prefetch_reg <= 1'b0;
      end
    end
  end

  // Interrupt sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maskable_irq_in_busy_reg <= 1'b0;
      inta_done_reg <= 2'h0;
      irq_dispatch <= '0;
    end else if (clk_en) begin
      irq_dispatch.valid <= 1'b0;
      if (nmi_taken) begin
        irq_dispatch <= '{valid: 1'b1, nmi: 1'b1, vector: NMI_VECTOR};
      end else if (!maskable_irq_in_busy_reg && maskable_irq_in_level && processor_flags_register[IF_BIT]) begin
        maskable_irq_in_busy_reg <= 1'b1;
        inta_done_reg <= 2'h0;
      end else if (cycle_end && is_inta_reg) begin
        inta_done_reg <= inta_done_reg + 2'h1;
        if (inta_done_reg == INTA_COUNT - 2'h1) begin
          irq_dispatch <= '{valid: 1'b1, nmi: 1'b0, vector: data_in[7:0]};
          maskable_irq_in_busy_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Pin drivers
  // ==========================================================
  logic addr_was_floated_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Takeover still granted while reset is held
      bus_request_out <= 1'b0;
      bus_grant_ack <= hold_s && !yield_s;
      cycle_start_strobe_n <= 1'b1;
      bus_oe_n <= 1'b1;
      addr_oe_n <= 1'b1;
      cycle_inta <= 1'b0;
      cycle_lock_n <= 1'b1;
      addr_out <= '0;
    end else if (clk_en) begin
      bus_request_out <= pending || (state_next == ST_START) || (state_next == ST_WAIT && more_reg);
      bus_grant_ack <= state_next == ST_HOLD;
      cycle_start_strobe_n <= !(state_next == ST_START);
      bus_oe_n <= state_next == ST_HOLD || state_next == ST_YIELD;
      addr_oe_n <= afloat_s || state_next == ST_HOLD || state_next == ST_YIELD;
      cycle_inta <= is_inta_reg || inta_want;
      cycle_lock_n <= !(state_next == ST_START || state_next == ST_WAIT) || !lock_seq;
      addr_out <= (state_reg == ST_IDLE && state_next == ST_START) ? addr_load : addr_reg;
    end
  end

  // Redrive tracking for address float
  always_ff @(posedge clk) begin
    if (!reset_n)
      addr_was_floated_reg <= 1'b0;
    else if (clk_en)
      addr_was_floated_reg <= afloat_s && state_reg == ST_WAIT && !ready_hit;
  end

  // Error outputs never float
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      parity_error_out_n <= 1'b1;
      fp_error_out_n <= 1'b1;
    end else if (clk_en) begin
      parity_error_out_n <= !parity_error;
      fp_error_out_n <= !fp_error;
    end
  end

  // Read data, dropped while backed off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_rdata <= '0;
      core_rdata_valid <= 1'b0;
      core_req_ready <= 1'b0;
    end else if (clk_en) begin
      core_rdata_valid <= state_reg == ST_WAIT && ready_hit && !is_inta_reg;
      core_rdata <= data_in;
      core_req_ready <= cycle_end && !is_inta_reg;
    end
  end

  // Snoop works in every bus state; strobe is synchronous
  always_ff @(posedge clk) begin
    if (!reset_n)
      snoop_inval <= '0;
    else if (clk_en) begin
      snoop_inval.valid <= !snoop_address_strobe_n;
      snoop_inval.line <= addr_in[ADDR_W-1:SNOOP_LSB];
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_grant_hold: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && bus_grant_ack |-> bus_oe_n) else $error("grant without float");
  a_yield_no_ack: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_YIELD |-> !bus_grant_ack) else $error("ack during backoff");
  a_start_single: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !cycle_start_strobe_n ##1 clk_en |-> cycle_start_strobe_n) else $error("strobe held");
  a_start_bus_request_out: assert property (@(posedge clk) disable iff (!reset_n)
    !cycle_start_strobe_n |-> bus_request_out) else $error("no request at start");
  a_nmi_vector: assert property (@(posedge clk) disable iff (!reset_n)
    irq_dispatch.valid && irq_dispatch.nmi |-> irq_dispatch.vector == NMI_VECTOR) else $error("bad nmi vector");
  a_yield_ready: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && yield_s |=> !core_rdata_valid) else $error("data in backoff");
  a_float_addr: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && afloat_s |=> addr_oe_n) else $error("address driven");
  a_snoop_pass: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !snoop_address_strobe_n |=> snoop_inval.valid) else $error("snoop lost");
  a_mask_if: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !maskable_irq_in_busy_reg && !nmi_taken && !processor_flags_register[IF_BIT] |=> !maskable_irq_in_busy_reg)
    else $error("maskable_irq_in taken with flag clear");
endmodule

// file: bus_far_model.sv
// Far-side model: memory and interrupt controller answering bus cycles
`timescale 1ns/1ps
module bus_far_model
  import bus_own_pkg::*;
#(
  parameter logic [7:0] VEC = 8'h5A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Cycle pins
  input wire logic cycle_start_strobe_n,
  input wire logic cycle_inta,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [3:0] dly,
  output cycle_term_t term,
  output logic [31:0] data_in
);
  logic [3:0] cnt_reg;
  logic busy_reg;
  logic [31:0] word_reg;

  // ==========================================
  // Answer
  initial begin
    term = 3'h7;
    data_in = 32'h0;
    busy_reg = 1'h0;
    cnt_reg = 4'h0;
    word_reg = 32'h0;
  end

  // Released data bus toggles so a stale word is never mistaken for data
  always @(posedge clk) begin
    term <= 3'h7;
    data_in <= ~data_in;
    if (!reset_n) begin
      busy_reg <= 1'h0;
    end else if (!cycle_start_strobe_n) begin
      busy_reg <= 1'h1;
      cnt_reg <= dly;
      word_reg <= cycle_inta ? {24'h0, VEC} : ~addr_out;
    end else if (busy_reg && cnt_reg == 4'h0) begin
      term <= 3'h2;
      data_in <= word_reg;
      busy_reg <= 1'h0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// file: testbench.sv
// Testbench for the bus ownership, interrupt and snoop block
`timescale 1ns/1ps
module testbench
  import bus_own_pkg::*;
;
  localparam logic [7:0] VEC = 8'h5A;
  logic clk, reset_n, clk_en, core_req_ready, core_rdata_valid, interrupt_return_instr;
  logic maskable_irq_in, nmi_in, hold_request, bus_yield_now_n, address_float_request;
  logic bus_request_out, bus_grant_ack, cycle_start_strobe_n, cycle_inta, addr_oe_n, bus_oe_n;
  logic snoop_address_strobe_n, parity_error, fp_error, parity_error_out_n, fp_error_out_n;
  logic self_test_req;
  logic [3:0] dly;
  logic [31:0] core_rdata, processor_flags_register, data_in, addr_out, addr_in;
  cycle_req_t core_req;
  cycle_term_t term;
  irq_dispatch_t irq_dispatch;
  snoop_t snoop_inval;
  int failures, n_checks;

  cpu_bus_ownership_irq_snoop u_cpu_bus_ownership_irq_snoop (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .core_req(core_req),
    .core_req_ready(core_req_ready), .core_rdata(core_rdata), .core_rdata_valid(core_rdata_valid),
    .processor_flags_register(processor_flags_register), .interrupt_return_instr(interrupt_return_instr),
    .irq_dispatch(irq_dispatch), .maskable_irq_in(maskable_irq_in), .nmi_in(nmi_in),
    .hold_request(hold_request), .bus_yield_now_n(bus_yield_now_n),
    .address_float_request(address_float_request), .bus_request_out(bus_request_out),
    .bus_grant_ack(bus_grant_ack), .cycle_start_strobe_n(cycle_start_strobe_n), .cycle_inta(cycle_inta),
    .cycle_lock_n(), .addr_out(addr_out), .addr_oe_n(addr_oe_n), .bus_oe_n(bus_oe_n), .term(term),
    .data_in(data_in), .addr_in(addr_in), .snoop_address_strobe_n(snoop_address_strobe_n),
    .parity_error(parity_error), .fp_error(fp_error), .parity_error_out_n(parity_error_out_n),
    .fp_error_out_n(fp_error_out_n), .snoop_inval(snoop_inval), .self_test_req(self_test_req));

  bus_far_model #(.VEC(VEC)) u_bus_far_model (
    .clk(clk), .reset_n(reset_n), .cycle_start_strobe_n(cycle_start_strobe_n), .cycle_inta(cycle_inta),
    .addr_out(addr_out), .dly(dly), .term(term), .data_in(data_in));

  // ==========================================
  // Helpers
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic req(input logic [31:0] a);
    core_req = '{1'h1, a, 1'h0, 1'h0, 1'h0};
  endtask

  task automatic wait_strobe;
    for (int i = 0; i < 30 && cycle_start_strobe_n !== 1'h0; i++) tick;
  endtask

  // Request held until the completion pulse, then withdrawn
  task automatic wait_done(output logic [31:0] rd);
    rd = 32'h0;
    for (int i = 0; i < 40 && core_req_ready !== 1'h1; i++) begin
      tick;
      if (core_rdata_valid === 1'h1) rd = core_rdata;
    end
    core_req.valid = 1'h0;
  endtask

  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_read;
    logic [31:0] rd;
    dly = 4'h2;
    req(32'h0000_1230);
    wait_strobe;
    chkb(cycle_start_strobe_n, 1'h0);
    chkb(bus_request_out, 1'h1);
    chk(addr_out, 32'h0000_1230);
    tick;
    chkb(cycle_start_strobe_n, 1'h1);
    wait_done(rd);
    chk(rd, ~32'h0000_1230);
  endtask

  task automatic t_bus_yield_now_n;
    logic [31:0] rd;
    logic bad;
    bad = 1'h0;
    dly = 4'h8;
    req(32'h0000_4560);
    wait_strobe;
    tick;
    bus_yield_now_n = 1'h0;
    for (int i = 0; i < 6 && bus_oe_n !== 1'h1; i++) tick;
    chkb(bus_oe_n, 1'h1);
    chkb(bus_grant_ack, 1'h0);
    repeat (10) begin
      tick;
      if (core_req_ready === 1'h1 || core_rdata_valid === 1'h1) bad = 1'h1;
    end
    chkb(bad, 1'h0);
    bus_yield_now_n = 1'h1;
    wait_strobe;
    chk(addr_out, 32'h0000_4560);
    wait_done(rd);
    chk(rd, ~32'h0000_4560);
  endtask

  task automatic t_hold;
    logic [31:0] rd;
    logic done;
    done = 1'h0;
    dly = 4'h3;
    req(32'h0000_7890);
    wait_strobe;
    hold_request = 1'h1;
    for (int i = 0; i < 30 && bus_grant_ack !== 1'h1; i++) begin
      tick;
      if (core_req_ready === 1'h1) begin
        done = 1'h1;
        core_req.valid = 1'h0;
      end
    end
    chkb(done, 1'h1);
    chkb(bus_oe_n, 1'h1);
    parity_error = 1'h1;
    fp_error = 1'h1;
    req(32'h0000_9AB0);
    repeat (4) tick;
    chkb(parity_error_out_n, 1'h0);
    chkb(fp_error_out_n, 1'h0);
    chkb(bus_request_out, 1'h1);
    addr_in = 32'hABCD_EF10;
    snoop_address_strobe_n = 1'h0;
    tick;
    snoop_address_strobe_n = 1'h1;
    for (int i = 0; i < 4 && snoop_inval.valid !== 1'h1; i++) tick;
    chk({4'h0, snoop_inval.line}, 32'h0ABC_DEF1);
    hold_request = 1'h0;
    for (int i = 0; i < 6 && bus_grant_ack !== 1'h0; i++) tick;
    chkb(bus_grant_ack, 1'h0);
    chkb(bus_oe_n, 1'h0);
    wait_strobe;
    chk(addr_out, 32'h0000_9AB0);
    wait_done(rd);
    parity_error = 1'h0;
    fp_error = 1'h0;
  endtask

  task automatic t_float;
    logic [31:0] rd;
    logic bad;
    bad = 1'h0;
    dly = 4'hF;
    req(32'h0000_5550);
    wait_strobe;
    tick;
    address_float_request = 1'h1;
    for (int i = 0; i < 6 && addr_oe_n !== 1'h1; i++) tick;
    chkb(addr_oe_n, 1'h1);
    chkb(bus_oe_n, 1'h0);
    repeat (4) tick;
    address_float_request = 1'h0;
    for (int i = 0; i < 6 && addr_oe_n !== 1'h0; i++) tick;
    chk(addr_out, 32'h0000_5550);
    wait_done(rd);
    chk(rd, ~32'h0000_5550);
    address_float_request = 1'h1;
    repeat (4) tick;
    dly = 4'h2;
    req(32'h0000_6660);
    repeat (8) begin
      tick;
      if (cycle_start_strobe_n === 1'h0) bad = 1'h1;
    end
    chkb(bad, 1'h0);
    address_float_request = 1'h0;
    wait_strobe;
    chkb(cycle_start_strobe_n, 1'h0);
    wait_done(rd);
  endtask

  task automatic t_irq;
    logic bad;
    int n;
    bad = 1'h0;
    n = 0;
    dly = 4'h2;
    processor_flags_register = 32'h0;
    maskable_irq_in = 1'h1;
    repeat (20) begin
      tick;
      if (irq_dispatch.valid === 1'h1 || cycle_start_strobe_n === 1'h0) bad = 1'h1;
    end
    chkb(bad, 1'h0);
    processor_flags_register = 32'h0000_0200;
    for (int i = 0; i < 80 && irq_dispatch.valid !== 1'h1; i++) begin
      tick;
      if (cycle_start_strobe_n === 1'h0 && cycle_inta === 1'h1) n++;
    end
    processor_flags_register = 32'h0;
    maskable_irq_in = 1'h0;
    chk(n, 2);
    chk({24'h0, irq_dispatch.vector}, {24'h0, VEC});
    chkb(irq_dispatch.nmi, 1'h0);
    processor_flags_register = 32'h0;
  endtask

  task automatic t_nmi;
    logic bad;
    int n;
    bad = 1'h0;
    n = 0;
    repeat (6) tick;
    nmi_in = 1'h1;
    for (int i = 0; i < 12 && irq_dispatch.valid !== 1'h1; i++) begin
      tick;
      if (cycle_start_strobe_n === 1'h0) n++;
    end
    chkb(irq_dispatch.nmi, 1'h1);
    chk({24'h0, irq_dispatch.vector}, {24'h0, NMI_VECTOR});
    chk(n, 0);
    tick;
    nmi_in = 1'h0;
    repeat (6) tick;
    nmi_in = 1'h1;
    repeat (15) begin
      tick;
      if (irq_dispatch.valid === 1'h1) bad = 1'h1;
    end
    chkb(bad, 1'h0);
    interrupt_return_instr = 1'h1;
    tick;
    interrupt_return_instr = 1'h0;
    nmi_in = 1'h0;
    repeat (6) tick;
    nmi_in = 1'h1;
    for (int i = 0; i < 12 && irq_dispatch.valid !== 1'h1; i++) tick;
    chkb(irq_dispatch.valid, 1'h1);
  endtask

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Whole run is under a thousand cycles; four thousand leaves room
  initial begin
    #(50 * 4000);
    failures++;
    print_verdict;
  end

  initial begin
    failures = 0;
    n_checks = 0;
    clk_en = 1'h1;
    reset_n = 1'h0;
    core_req = '0;
    processor_flags_register = 32'h0;
    interrupt_return_instr = 1'h0;
    maskable_irq_in = 1'h0;
    nmi_in = 1'h0;
    hold_request = 1'h1;
    bus_yield_now_n = 1'h1;
    address_float_request = 1'h1;
    addr_in = 32'h0;
    snoop_address_strobe_n = 1'h1;
    parity_error = 1'h0;
    fp_error = 1'h0;
    dly = 4'h2;
    repeat (15) tick;
    chkb(bus_grant_ack, 1'h1);
    reset_n = 1'h1;
    repeat (3) tick;
    chkb(self_test_req, 1'h1);
    hold_request = 1'h0;
    address_float_request = 1'h0;
    repeat (8) tick;
    chkb(bus_grant_ack, 1'h0);
    t_read;
    t_bus_yield_now_n;
    t_hold;
    t_float;
    t_irq;
    t_nmi;
    print_verdict;
  end
endmodule
